// ===== fault_flag_params.svh
// fault_flag_params.svh: offsets, bit positions, reset values and timing
// counts for the fault flag reporting block.
// assumes a 100 MHz register clock and a 32-bit apb register bus.
`ifndef FAULT_FLAG_PARAMS_SVH
`define FAULT_FLAG_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_STATUS 12'h000
`define REG_FAULT_PIN_BRIDGE 12'h004
`define REG_FAULT_PIN_SUPPLY 12'h008
`define REG_MASK 12'h00c
`define REG_CONFIG 12'h010
`define REG_IRQ_STATUS 12'h014
`define REG_IRQ_MASK 12'h018

// ----------------------------------------------------------------------
// latched fault vector layout
// ----------------------------------------------------------------------
`define NUM_FAULTS 21
`define FB_POR 0
`define FB_OVERTEMP 1
`define FB_LINK 2
`define FB_NVM 3
`define FB_SUPPLY 4
`define FB_OVERCURRENT 11
`define FB_BOOT 12
`define FB_VDS 15
`define MASKABLE 21'h1ffff0
`define CLR_STATUS 21'h000ff7
`define CLR_FAULT_PIN_BRIDGE 21'h1ff000
`define CLR_FAULT_PIN_SUPPLY 21'h0000f0
`define FLAGS_RESET 21'h000001

// status word summary bits
`define ST_BOOT_BIT 12
`define ST_VDS_BIT 13
`define ST_ANY_BIT 15

// irq bits: fault newly latched, bus transfer rejected
`define IRQ_NEW_FAULT 0
`define IRQ_REJECT 1

// ----------------------------------------------------------------------
// fault pin pulse timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define PULSE_PERIOD_MS 100
`define DUTY_FAULT_PCT 20
`define DUTY_OK_PCT 80
`define PULSE_PERIOD_CYC (`PULSE_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ===== fault_flag_pkg.sv
// fault_flag_pkg: types shared by the fault flag reporting files.
// assumes nothing of its surroundings.
package fault_flag_pkg;

    // fault pin function, in the order of the two select bits
    typedef enum logic [1:0] {
        PIN_LEVEL,
        PIN_PULSE,
        PIN_LEVEL_ALT,
        PIN_CLOCK
    } pin_mode_e;

    // software configuration word
    typedef struct packed {
        logic keep_faults_on_read;
        logic [1:0] fault_pin_select;
    } cfg_s;

    // synchronised inputs from the fault detectors
    typedef struct packed {
        logic outputs_disabled;
        logic [20:0] src;
    } det_s;

endpackage : fault_flag_pkg

// ===== fault_flag_reporting.sv
// fault_flag_reporting: latches chip, monitor and bridge faults, serves
// them over apb and drives the open-drain fault pin.
// assumes fault detectors, strobe and disable inputs are asynchronous.
//
// Overview of operation
// - status bit 15 is set while any latched fault bit is set.
// - the fault flag appears on the serial first bit when the strobe falls.
// - fault bits stay latched until read with keep_faults_on_read low.
// - with keep_faults_on_read high a read clears nothing.
// - noncritical faults are maskable; chip-level faults are not.
// - twenty-one fault sources in chip, monitor and bridge classes.
// - the status register can be read at any time.
// - diagnostic registers name the exact vds, boot or supply fault.
// - fault_pin_select picks level, pulsed or clock pin function.
// - level mode pulls the pin low while a fault or disable is present.
// - pulsed mode runs a continuous 100 ms period.
// - pulsed duty is 20 percent with a fault, 80 percent without.
// - the fault pin is open-drain, only ever pulled low.
// - a rejected transfer clears nothing and sets link_transfer_fault.
// - the nvm integrity fault clears only by power-on reset.
// - power-on reset sets any_fault_flag and the power-on flag.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "fault_flag_params.svh"
module fault_flag_reporting #(
    parameter int PULSE_PERIOD_CYC = `PULSE_PERIOD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [20:0] fault_in,
    input wire logic outputs_disabled,
    input wire logic serial_strobe_n,
    output logic serial_first_bit,
    output logic serial_first_bit_oe,
    output logic fault_pin_o,
    output logic fault_pin_oe,
    output logic any_fault_flag,
    output logic irq
);
    localparam int N = `NUM_FAULTS;
    localparam int HI_FAULT_CYC = PULSE_PERIOD_CYC * `DUTY_FAULT_PCT / 100;
    localparam int HI_OK_CYC = PULSE_PERIOD_CYC * `DUTY_OK_PCT / 100;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fault_flag_pkg::det_s det_s1_q;
    fault_flag_pkg::det_s det_q;
    logic strobe_s1_q;
    logic strobe_q;
    logic [N-1:0] flags_q;
    logic [N-1:0] flags_d;
    logic ff_q;
    logic [N-1:0] mask_q;
    fault_flag_pkg::cfg_s cfg_q;
    logic [1:0] irq_st_q;
    logic [1:0] irq_st_d;
    logic [1:0] irq_en_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic [N-1:0] clr_q;
    logic pin_oe_q;
    logic clk_q;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic setup;
    logic fire;
    logic wr_fire;
    logic rd_fire;
    logic hit_status;
    logic hit_bridge;
    logic hit_supply;
    logic hit_mask;
    logic hit_cfg;
    logic hit_ist;
    logic hit_ien;
    logic read_only;
    logic bad_req;
    logic [N-1:0] rd_clr;
    logic [31:0] rd_mux;
    logic [N-1:0] mask_eff;
    logic [N-1:0] src_eff;
    logic [N-1:0] set_v;
    logic fault_now;
    logic pulse_high;
    logic want_low;
    fault_flag_pkg::pin_mode_e mode;

    // status word: chip and monitor bits low, bridge summaries above
    function automatic logic [31:0] status_word(input logic [N-1:0] f, input logic ff);
        logic [31:0] w;
        w = '0;
        w[`FB_OVERCURRENT:0] = f[`FB_OVERCURRENT:0];
        w[`ST_BOOT_BIT] = |f[`FB_BOOT +: 3];
        w[`ST_VDS_BIT] = |f[`FB_VDS +: 6];
        w[`ST_ANY_BIT] = ff;
        return w;
    endfunction : status_word

    // widen a narrow field to a bus word with zero upper bits
    function automatic logic [31:0] zext(input logic [N-1:0] v);
        return {{(32 - N){1'b0}}, v};
    endfunction : zext

    // bus phases; the answer is ready on the first access cycle
    assign setup = psel & ~penable & ce;
    assign pready = psel & penable & ce;
    assign fire = pready & ~err_q;
    assign wr_fire = fire & pwrite;
    assign rd_fire = fire & ~pwrite;
    assign pslverr = pready & err_q;
    assign prdata = rdata_q;

    // address decode
    assign hit_status = (paddr == `REG_STATUS);
    assign hit_bridge = (paddr == `REG_FAULT_PIN_BRIDGE);
    assign hit_supply = (paddr == `REG_FAULT_PIN_SUPPLY);
    assign hit_mask = (paddr == `REG_MASK);
    assign hit_cfg = (paddr == `REG_CONFIG);
    assign hit_ist = (paddr == `REG_IRQ_STATUS);
    assign hit_ien = (paddr == `REG_IRQ_MASK);
    assign read_only = hit_status | hit_bridge | hit_supply;
    // unmapped addresses and writes to the fault words are rejected
    assign bad_req = ~(read_only | hit_mask | hit_cfg | hit_ist | hit_ien)
        | (pwrite & read_only);

    // bits that a read of each fault word will clear; nvm is never here
    assign rd_clr = hit_status ? `CLR_STATUS
        : hit_bridge ? `CLR_FAULT_PIN_BRIDGE
        : hit_supply ? `CLR_FAULT_PIN_SUPPLY : '0;

    // read mux; status has no gating on bridge or fault state
    assign rd_mux = hit_status ? status_word(flags_q, ff_q)
        : hit_bridge ? zext(flags_q & `CLR_FAULT_PIN_BRIDGE) >> `FB_BOOT
        : hit_supply ? zext(flags_q & `CLR_FAULT_PIN_SUPPLY) >> `FB_SUPPLY
        : hit_mask ? zext(mask_q)
        : hit_cfg ? {29'h0000000, cfg_q}
        : hit_ist ? {30'h00000000, irq_st_q}
        : hit_ien ? {30'h00000000, irq_en_q} : 32'h00000000;

    // ------------------------------------------------------------------
    // fault latching
    // ------------------------------------------------------------------
    // chip-level sources ignore the mask, the rest obey it
    assign mask_eff = mask_q & `MASKABLE;
    assign src_eff = det_q.src & ~mask_eff;
    // a rejected transfer raises the link fault bit itself
    assign set_v = src_eff | (N'(pslverr) << `FB_LINK);

    // read clears only bits that were returned; new sets always win
    always_comb begin
        flags_d = flags_q;
        if (rd_fire && !cfg_q.keep_faults_on_read) begin
            flags_d = flags_q & ~clr_q;
        end
        flags_d = flags_d | set_v;
    end

    // interrupt status: sticky, write one to clear, set wins
    always_comb begin
        irq_st_d = irq_st_q;
        if (wr_fire && hit_ist) begin
            irq_st_d = irq_st_q & ~pwdata[1:0];
        end
        irq_st_d[`IRQ_NEW_FAULT] = irq_st_d[`IRQ_NEW_FAULT] | (|(set_v & ~flags_q));
        irq_st_d[`IRQ_REJECT] = irq_st_d[`IRQ_REJECT] | pslverr;
    end
    assign irq = |(irq_st_q & irq_en_q);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    // detector levels and the strobe pin pass two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_s1_q <= '0;
            det_q <= '0;
            strobe_s1_q <= 1'b1;
            strobe_q <= 1'b1;
        end else if (ce) begin
            det_s1_q <= {outputs_disabled, fault_in};
            det_q <= det_s1_q;
            strobe_s1_q <= serial_strobe_n;
            strobe_q <= strobe_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // fault registers
    // ------------------------------------------------------------------
    // reset leaves the power-on flag and the common flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= `FLAGS_RESET;
            ff_q <= 1'b1;
        end else if (ce) begin
            flags_q <= flags_d;
            ff_q <= |flags_d;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
            cfg_q <= '0;
            irq_en_q <= 2'b00;
            irq_st_q <= 2'b00;
        end else if (ce) begin
            if (wr_fire && hit_mask) begin
                mask_q <= pwdata[N-1:0];
            end
            if (wr_fire && hit_cfg) begin
                cfg_q <= pwdata[2:0];
            end
            if (wr_fire && hit_ien) begin
                irq_en_q <= pwdata[1:0];
            end
            irq_st_q <= irq_st_d;
        end
    end

    // read data and error are fixed in the setup cycle, so the bits a
    // read clears are exactly the bits the master saw
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
            err_q <= 1'b0;
            clr_q <= '0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h00000000 : rd_mux;
            err_q <= bad_req;
            clr_q <= rd_clr & flags_q;
        end
    end

    // ------------------------------------------------------------------
    // serial poll bit
    // ------------------------------------------------------------------
    // the common flag is driven whenever the strobe is low
    assign serial_first_bit = ff_q;
    assign serial_first_bit_oe = ~strobe_q;
    assign any_fault_flag = ff_q;

    // ------------------------------------------------------------------
    // fault pin
    // ------------------------------------------------------------------
    // present fault: live unmasked source or disabled outputs
    assign fault_now = (|src_eff) | det_q.outputs_disabled;
    assign mode = fault_flag_pkg::pin_mode_e'(cfg_q.fault_pin_select);

    pulse_gen #(
        .PERIOD_CYC(PULSE_PERIOD_CYC),
        .HI_FAULT_CYC(HI_FAULT_CYC),
        .HI_OK_CYC(HI_OK_CYC)
    ) u_pulse (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .fault(fault_now),
        .pulse_high(pulse_high)
    );

    // pin function select
    always_comb begin
        unique case (mode)
            fault_flag_pkg::PIN_LEVEL: want_low = fault_now;
            fault_flag_pkg::PIN_PULSE: want_low = ~pulse_high;
            fault_flag_pkg::PIN_LEVEL_ALT: want_low = fault_now;
            fault_flag_pkg::PIN_CLOCK: want_low = clk_q;
        endcase
    end

    // registered enable keeps glitches off the pin; clock is pclk / 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe_q <= 1'b0;
            clk_q <= 1'b0;
        end else if (ce) begin
            pin_oe_q <= want_low;
            clk_q <= ~clk_q;
        end
    end

    // open drain: only ever pulls low, released high by the pull-up
    assign fault_pin_o = 1'b0;
    assign fault_pin_oe = pin_oe_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ff_follows;
        ce && (|src_eff) |=> any_fault_flag && (|flags_q);
    endproperty
    a_ff_follows: assert property (p_ff_follows)
        else $error("unmasked fault did not raise the common flag");

    property p_poll_bit;
        !strobe_q |-> serial_first_bit_oe && serial_first_bit == ff_q;
    endproperty
    a_poll_bit: assert property (p_poll_bit)
        else $error("poll bit not presented while strobe low");

    property p_read_clears;
        rd_fire && hit_status && !cfg_q.keep_faults_on_read
            |=> (flags_q & $past(clr_q & ~src_eff)) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear its fault bits");

    property p_keep;
        rd_fire && cfg_q.keep_faults_on_read |=> (flags_q & $past(flags_q)) == $past(flags_q);
    endproperty
    a_keep: assert property (p_keep)
        else $error("read with keep set cleared a fault bit");

    property p_reject;
        pslverr |=> flags_q[`FB_LINK] && irq_st_q[`IRQ_REJECT]
            && ((flags_q & $past(flags_q)) == $past(flags_q));
    endproperty
    a_reject: assert property (p_reject)
        else $error("rejected transfer cleared bits or missed link fault");

    property p_nvm_sticky;
        flags_q[`FB_NVM] |=> flags_q[`FB_NVM];
    endproperty
    a_nvm_sticky: assert property (p_nvm_sticky)
        else $error("nvm integrity fault cleared without reset");

    property p_masked;
        ce && mask_q[`FB_OVERCURRENT] && !flags_q[`FB_OVERCURRENT]
            |=> !flags_q[`FB_OVERCURRENT];
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked overcurrent was latched");

    property p_level_pin;
        ce && (mode == fault_flag_pkg::PIN_LEVEL) |=> fault_pin_oe == $past(fault_now);
    endproperty
    a_level_pin: assert property (p_level_pin)
        else $error("level mode pin does not follow fault state");

    property p_clock_pin;
        ce && (mode == fault_flag_pkg::PIN_CLOCK) ##1 ce && (mode == fault_flag_pkg::PIN_CLOCK)
            |=> fault_pin_oe != $past(fault_pin_oe);
    endproperty
    a_clock_pin: assert property (p_clock_pin)
        else $error("clock mode pin failed to toggle");

endmodule : fault_flag_reporting

// ===== fault_flag_reporting_bench.sv
// fault_flag_reporting_bench: self-checking bench for fault flag reporting.
// assumes the params header is on the include path and a 100 mhz pclk.
`timescale 1ns/1ps
`include "fault_flag_params.svh"
module fault_flag_reporting_bench;
    localparam int PER = 100;
    typedef struct {
        logic [20:0] f;
        logic [11:0] a;
        logic [31:0] x;
    } row_s;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [20:0] fault_in;
    logic outputs_disabled, serial_strobe_n, serial_first_bit, serial_first_bit_oe;
    logic fault_pin_o, fault_pin_oe, any_fault_flag, irq, pin_level, line_level, b, ok;
    int miscompares = 0;
    int samples_checked = 0;
    int hi;
    // one fault source per row, the register that shows it, the word read
    row_s rows [11] = '{'{21'h2, `REG_STATUS, 32'h8002}, '{21'h4, `REG_STATUS, 32'h8004},
        '{21'h10, `REG_FAULT_PIN_SUPPLY, 32'h1}, '{21'h80, `REG_FAULT_PIN_SUPPLY, 32'h8},
        '{21'h100, `REG_STATUS, 32'h8100}, '{21'h400, `REG_STATUS, 32'h8400},
        '{21'h800, `REG_STATUS, 32'h8800}, '{21'h2000, `REG_FAULT_PIN_BRIDGE, 32'h2},
        '{21'h1000, `REG_STATUS, 32'h9000}, '{21'h8000, `REG_STATUS, 32'ha000},
        '{21'h100000, `REG_FAULT_PIN_BRIDGE, 32'h100}};

    fault_flag_reporting #(.PULSE_PERIOD_CYC(PER)) fault_flag_reporting_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fault_in(fault_in),
        .outputs_disabled(outputs_disabled), .serial_strobe_n(serial_strobe_n),
        .serial_first_bit(serial_first_bit), .serial_first_bit_oe(serial_first_bit_oe),
        .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .any_fault_flag(any_fault_flag), .irq(irq));

    host_model host_model_i (
        .pclk(pclk), .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .serial_first_bit(serial_first_bit), .serial_first_bit_oe(serial_first_bit_oe),
        .serial_strobe_n(serial_strobe_n), .pin_level(pin_level), .line_level(line_level));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // compare, report and bus tasks
    // ------------------------------------------------------------------
    task check32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check32

    task check1(input logic got, input logic exp);
        check32({31'h0, got}, {31'h0, exp});
    endtask : check1

    task print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // one apb transfer; the wait for pready is bounded so a hang ends the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd_q, err_q);
        check32(rd_q, x);
    endtask : rd

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd_q, err_q);
    endtask : wr

    // a short fault burst, long enough to pass the two-stage synchroniser
    task pulse(input logic [20:0] f);
        @(posedge pclk);
        fault_in <= f;
        repeat (4) @(posedge pclk);
        fault_in <= 21'h0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    // read everything once so that every clearable bit goes away
    task clean();
        wr(`REG_CONFIG, 32'h0);
        apb(1'b0, `REG_FAULT_PIN_BRIDGE, 32'h0, rd_q, err_q);
        apb(1'b0, `REG_FAULT_PIN_SUPPLY, 32'h0, rd_q, err_q);
        apb(1'b0, `REG_STATUS, 32'h0, rd_q, err_q);
    endtask : clean

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'h0, 12'h0, 32'h0};
        {fault_in, outputs_disabled, presetn} = 23'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check1(any_fault_flag, 1'b1);
        host_model_i.poll(b, ok);
        check32({30'h0, ok, b}, 32'h3);
        rd(`REG_STATUS, 32'h8001);
        rd(`REG_STATUS, 32'h0);
        repeat (2) @(posedge pclk);
        check1(any_fault_flag, 1'b0);
        host_model_i.poll(b, ok);
        check32({30'h0, ok, b}, 32'h2);
        foreach (rows[i]) begin
            pulse(rows[i].f);
            rd(rows[i].a, rows[i].x);
            clean();
            rd(`REG_STATUS, 32'h0);
        end
        // keep on read, then clear on read
        wr(`REG_CONFIG, 32'h4);
        pulse(21'h2);
        rd(`REG_STATUS, 32'h8002);
        rd(`REG_STATUS, 32'h8002);
        wr(`REG_CONFIG, 32'h0);
        rd(`REG_STATUS, 32'h8002);
        rd(`REG_STATUS, 32'h0);
        // chip-level bit ignores its mask, thermal warning and overcurrent obey it
        wr(`REG_MASK, 32'h902);
        pulse(21'h902);
        rd(`REG_STATUS, 32'h8002);
        fault_in <= 21'h100;
        repeat (4) @(posedge pclk);
        check1(pin_level, 1'b1);
        fault_in <= 21'h0;
        wr(`REG_MASK, 32'h0);
        // level modes 0 and 2: present fault or disable pulls the pin low
        for (int m = 0; m < 3; m += 2) begin
            wr(`REG_CONFIG, 32'(m));
            fault_in <= 21'h800;
            repeat (4) @(posedge pclk);
            check1(pin_level, 1'b0);
            fault_in <= 21'h0;
            outputs_disabled <= 1'b1;
            repeat (4) @(posedge pclk);
            check1(pin_level, 1'b0);
            outputs_disabled <= 1'b0;
            repeat (4) @(posedge pclk);
            check1(pin_level, 1'b1);
            clean();
        end
        // clock mode toggles every cycle
        wr(`REG_CONFIG, 32'h3);
        repeat (2) @(posedge pclk);
        b = pin_level;
        @(posedge pclk);
        check1(pin_level, ~b);
        // clock enable low freezes the pin in whatever state it has
        ce <= 1'b0;
        @(posedge pclk);
        b = pin_level;
        repeat (2) @(posedge pclk);
        check1(pin_level, b);
        ce <= 1'b1;
        // pulsed mode: released time over one whole period, then with a fault
        wr(`REG_CONFIG, 32'h1);
        for (int k = 0; k < 2; k++) begin
            fault_in <= (k == 1) ? 21'h800 : 21'h0;
            repeat (PER) @(posedge pclk);
            hi = 0;
            repeat (PER) begin
                @(posedge pclk);
                hi += int'(pin_level);
            end
            check32(32'(hi), (k == 1) ? 32'd20 : 32'd80);
        end
        fault_in <= 21'h0;
        clean();
        // rejected transfers and the interrupt path
        wr(`REG_IRQ_STATUS, 32'h3);
        wr(`REG_IRQ_MASK, 32'h0);
        apb(1'b1, `REG_STATUS, 32'hffff, rd_q, err_q);
        check1(err_q, 1'b1);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b0);
        wr(`REG_IRQ_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b1);
        wr(`REG_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b0);
        rd(`REG_STATUS, 32'h8004);
        pulse(21'h2);
        apb(1'b0, 12'h0ff, 32'h0, rd_q, err_q);
        check1(err_q, 1'b1);
        rd(`REG_STATUS, 32'h8006);
        rd(`REG_IRQ_STATUS, 32'h3);
        // memory integrity fault survives reads, only reset clears it
        pulse(21'h8);
        rd(`REG_STATUS, 32'h8008);
        rd(`REG_STATUS, 32'h8008);
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`REG_STATUS, 32'h8001);
        print_verdict();
    end
endmodule : fault_flag_reporting_bench

// ===== host_model.sv
// host_model: host side of the fault pin and the serial fault poll.
// assumes a pull-up on the fault pin and a host that acts after rising edges.
`timescale 1ns/1ps
module host_model (
    input wire logic pclk,
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    input wire logic serial_first_bit,
    input wire logic serial_first_bit_oe,
    output logic serial_strobe_n,
    output logic pin_level,
    output logic line_level
);
    logic last_q;

    // open-drain pin: the pull-up wins whenever the driver lets go
    assign pin_level = fault_pin_oe ? fault_pin_o : 1'b1;
    // a released poll line has no pull: show the inverse of the last bit
    assign line_level = serial_first_bit_oe ? serial_first_bit : ~last_q;

    // remember the last driven bit of the poll line
    always_ff @(posedge pclk) begin
        if (serial_first_bit_oe) begin
            last_q <= serial_first_bit;
        end
    end

    initial begin
        serial_strobe_n = 1'b1;
    end

    // poll: strobe low, wait a bounded time for the line, take one bit
    task poll(output logic b, output logic ok);
        int n;
        @(posedge pclk);
        serial_strobe_n <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (serial_first_bit_oe !== 1'b1 && n < 8);
        ok = serial_first_bit_oe;
        b = line_level;
        serial_strobe_n <= 1'b1;
    endtask : poll
endmodule : host_model

// ===== pulse_gen.sv
// pulse_gen: periodic waveform for the fault pin pulsed mode.
// assumes fault is a level on pclk; high time switches at once.
`timescale 1ns/1ps
module pulse_gen #(
    parameter int PERIOD_CYC = 10000000,
    parameter int HI_FAULT_CYC = 2000000,
    parameter int HI_OK_CYC = 8000000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic fault,
    output logic pulse_high
);
    localparam int W = $clog2(PERIOD_CYC);
    localparam logic [W-1:0] LAST = W'(PERIOD_CYC - 1);

    logic [W-1:0] cnt_q;
    logic [W-1:0] thr;
    logic pulse_q;

    // duty threshold follows the present fault state
    assign thr = fault ? W'(HI_FAULT_CYC) : W'(HI_OK_CYC);
    assign pulse_high = pulse_q;

    // free running period counter, runs whatever the fault state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            pulse_q <= (cnt_q < thr);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // the counter wraps at the period end and never passes it
    property p_period_wrap;
        ce && cnt_q == LAST |=> cnt_q == '0;
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("pulse period counter did not wrap");

endmodule : pulse_gen
